// *** verilog/spmc_pkg.sv ***
// Constants, mode type and mode decode for the serial pin mode control.
// Assumes one clock domain; pins are sampled by the main module.

`default_nettype none

package spmc_pkg;

	// ****************************************
	// Pin map
	// ****************************************
	localparam int SPMC_NUM_SEL  = 4;
	localparam int SPMC_NUM_PINS = 7;
	localparam int PIN_SCLK      = 0;
	localparam int PIN_SEL0      = 1;
	localparam int PIN_SEL1      = 2;
	localparam int PIN_SEL3      = 4;
	localparam int PIN_MOSI      = 5;
	localparam int PIN_MISO      = 6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_PIN_OUT   = 1'h0;
	localparam logic RST_PIN_OE_N  = 1'h1;
	localparam logic RST_FAULT     = 1'h0;
	localparam logic RST_LAST_BIT  = 1'h0;
	localparam logic RST_SYNC      = 1'h1;
	localparam logic [3:0] RST_PORT_FREE = 4'hF;

	// ****************************************
	// Operating modes
	// ****************************************
	typedef enum logic [4:0] {
		MODE_SINGLE_MASTER = 5'h01,
		MODE_MULTI_MASTER  = 5'h02,
		MODE_SLAVE_SPI     = 5'h04,
		MODE_MASTER_SYNC   = 5'h08,
		MODE_SLAVE_SYNC    = 5'h10
	} spmc_mode_t;

	// Master with fault detection in clock-synchronous form runs as plain sync master
	function automatic spmc_mode_t spmc_decode_mode(input logic master,
		input logic faultEn, input logic syncForm);
		spmc_mode_t m;
		m = MODE_SLAVE_SPI;
		if (master && syncForm)
			m = MODE_MASTER_SYNC;
		else if (master && faultEn)
			m = MODE_MULTI_MASTER;
		else if (master)
			m = MODE_SINGLE_MASTER;
		else if (syncForm)
			m = MODE_SLAVE_SYNC;
		return m;
	endfunction

endpackage

`default_nettype wire

// *** verilog/spmc_pin_driver.sv ***
// One pin output stage: mux gating, push-pull or open-drain, registered.
// Assumes want/value come from logic on the same clock.

`timescale 1ns/1ps
`default_nettype none

module spmc_pin_driver (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Control
	input  wire logic funcSel,
	input  wire logic openDrain,
	input  wire logic driveWant,
	input  wire logic driveValue,
	// Pin
	output var  logic pinOut,
	output var  logic pinOeN
);
	import spmc_pkg::*;

	// ****************************************
	// Output stage
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pinOut <= RST_PIN_OUT;
			pinOeN <= RST_PIN_OE_N;
		end else if (!funcSel || !driveWant) begin
			pinOut <= RST_PIN_OUT;
			pinOeN <= 1'h1;
		end else if (openDrain) begin
			pinOut <= 1'h0;
			pinOeN <= driveValue;
		end else begin
			pinOut <= driveValue;
			pinOeN <= 1'h0;
		end
	end

endmodule // spmc_pin_driver

`default_nettype wire

// *** verilog/spmc_pin_mode_control.sv ***
// Pin direction, drive type and idle-level control of a serial peripheral unit.
// Assumes the transfer core runs on clk; pins and link clock arrive asynchronously.

`timescale 1ns/1ps
`default_nettype none

module spmc_pin_mode_control (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// Mode and drive settings
	input  wire logic                   masterSelectBit,
	input  wire logic                   faultDetectEnable,
	input  wire logic                   clockSyncFormSelect,
	input  wire logic                   unitEnableBit,
	input  wire logic                   idleFixingEnable,
	input  wire logic                   idleLevelBit,
	input  wire logic [spmc_pkg::SPMC_NUM_PINS-1:0] portOpenDrainSelect,
	input  wire logic [spmc_pkg::SPMC_NUM_PINS-1:0] pinFunctionSelect,
	// Transfer core
	input  wire logic                   coreSerialClock,
	input  wire logic [spmc_pkg::SPMC_NUM_SEL-1:0]  coreSelectOut,
	input  wire logic                   coreOutboundData,
	input  wire logic                   coreSlaveData,
	input  wire logic                   coreSelectNegated,
	input  wire logic                   modeFaultClear,
	// Pin inputs
	input  wire logic                   serialClockPinIn,
	input  wire logic [spmc_pkg::SPMC_NUM_SEL-1:0]  selectLinePinIn,
	input  wire logic                   outboundDataPinIn,
	input  wire logic                   inboundDataPinIn,
	// Pin outputs, enable low while driving
	output var  logic [spmc_pkg::SPMC_NUM_PINS-1:0] pinOut,
	output var  logic [spmc_pkg::SPMC_NUM_PINS-1:0] pinOeN,
	// Status to core and port logic
	output var  logic                   serialClockRise,
	output var  logic                   serialClockFall,
	output var  logic                   slaveSelected,
	output var  logic                   sampledInboundData,
	output var  logic                   sampledOutboundData,
	output var  logic                   modeFault,
	output var  logic                   busOwned,
	output var  logic [spmc_pkg::SPMC_NUM_SEL-1:0]  selectPortFree
);
	import spmc_pkg::*;

	spmc_mode_t                 mode;
	logic [SPMC_NUM_PINS-1:0]   pinRaw;
	logic [SPMC_NUM_PINS-1:0]   syncFirst;
	logic [SPMC_NUM_PINS-1:0]   syncPin;
	logic                       sclkPrev;
	logic                       sel0Low;
	logic                       lastBit;
	logic                       idleValue;
	logic                       masterSpi;
	logic [SPMC_NUM_PINS-1:0]   driveWant;
	logic [SPMC_NUM_PINS-1:0]   driveValue;
	logic [SPMC_NUM_SEL-1:0]    next_selectPortFree;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ****************************************
	// Mode decode
	// ****************************************
	assign mode = spmc_decode_mode(masterSelectBit, faultDetectEnable, clockSyncFormSelect);
	assign masterSpi = (mode == MODE_SINGLE_MASTER) || (mode == MODE_MULTI_MASTER);

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	assign pinRaw = {inboundDataPinIn, outboundDataPinIn, selectLinePinIn, serialClockPinIn};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncFirst <= {SPMC_NUM_PINS{RST_SYNC}};
			syncPin   <= {SPMC_NUM_PINS{RST_SYNC}};
		end else begin
			syncFirst <= pinRaw;
			syncPin   <= syncFirst;
		end
	end

	assign sel0Low = !syncPin[PIN_SEL0];

	// Serial clock edge finder on the sampled link clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sclkPrev <= RST_SYNC;
		else
			sclkPrev <= syncPin[PIN_SCLK];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			serialClockRise <= 1'h0;
			serialClockFall <= 1'h0;
		end else begin
			serialClockRise <= syncPin[PIN_SCLK] && !sclkPrev;
			serialClockFall <= !syncPin[PIN_SCLK] && sclkPrev;
		end
	end

	// ****************************************
	// Sampled data and selection toward the core
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			slaveSelected       <= 1'h0;
			sampledInboundData  <= 1'h0;
			sampledOutboundData <= 1'h0;
		end else begin
			// A select tied low keeps the slave selected across transfers
			slaveSelected <= (mode == MODE_SLAVE_SYNC) ||
				((mode == MODE_SLAVE_SPI) && sel0Low && unitEnableBit);
			sampledInboundData  <= syncPin[PIN_MISO];
			sampledOutboundData <= syncPin[PIN_MOSI];
		end
	end

	// ****************************************
	// Mode fault
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			modeFault <= RST_FAULT;
		else if ((mode == MODE_MULTI_MASTER) && sel0Low)
			modeFault <= 1'h1;
		else if (modeFaultClear)
			modeFault <= 1'h0;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			busOwned <= 1'h0;
		else
			busOwned <= (mode == MODE_SINGLE_MASTER) || (mode == MODE_MASTER_SYNC) ||
				((mode == MODE_MULTI_MASTER) && !sel0Low && !modeFault);
	end

	// ****************************************
	// Outbound data idle level
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			lastBit <= RST_LAST_BIT;
		else if (!coreSelectNegated)
			lastBit <= coreOutboundData;
	end

	always_comb begin
		idleValue = coreOutboundData;
		if (masterSpi && coreSelectNegated) begin
			if (idleFixingEnable)
				idleValue = idleLevelBit;
			else
				idleValue = lastBit;
		end
	end

	// ****************************************
	// Drive selection per mode
	// ****************************************
	always_comb begin
		driveWant = '0;
		driveValue = {coreSlaveData, idleValue, coreSelectOut, coreSerialClock};
		case (mode)
			MODE_SINGLE_MASTER: begin
				driveWant[PIN_MOSI:PIN_SCLK] = '1;
			end
			MODE_MULTI_MASTER: begin
				if (!sel0Low && !modeFault) begin
					driveWant[PIN_SCLK] = 1'h1;
					driveWant[PIN_SEL3:PIN_SEL1] = '1;
					driveWant[PIN_MOSI] = 1'h1;
				end
			end
			MODE_SLAVE_SPI: begin
				driveWant[PIN_MISO] = unitEnableBit && sel0Low;
			end
			MODE_MASTER_SYNC: begin
				driveWant[PIN_SCLK] = 1'h1;
				driveWant[PIN_MOSI] = 1'h1;
			end
			MODE_SLAVE_SYNC: begin
				driveWant[PIN_MISO] = 1'h1;
			end
			default: begin
				driveWant = '0;
			end
		endcase
	end

	// ****************************************
	// Select lines released to port logic
	// ****************************************
	always_comb begin
		next_selectPortFree = '0;
		case (mode)
			MODE_SINGLE_MASTER: next_selectPortFree = 4'h0;
			MODE_MULTI_MASTER:  next_selectPortFree = 4'h0;
			MODE_SLAVE_SPI:     next_selectPortFree = 4'hE;
			MODE_MASTER_SYNC:   next_selectPortFree = 4'hF;
			MODE_SLAVE_SYNC:    next_selectPortFree = 4'hF;
			default:            next_selectPortFree = 4'hF;
		endcase
		// A pin the multiplexer gives elsewhere is never claimed here
		next_selectPortFree = next_selectPortFree |
			~pinFunctionSelect[PIN_SEL3:PIN_SEL0];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			selectPortFree <= RST_PORT_FREE;
		else
			selectPortFree <= next_selectPortFree;
	end

	// ****************************************
	// Output stages
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < SPMC_NUM_PINS; gi++) begin : gPin
			spmc_pin_driver uDrv (
				.clk        (clk),
				.reset      (reset),
				.funcSel    (pinFunctionSelect[gi]),
				.openDrain  (portOpenDrainSelect[gi]),
				.driveWant  (driveWant[gi]),
				.driveValue (driveValue[gi]),
				.pinOut     (pinOut[gi]),
				.pinOeN     (pinOeN[gi])
			);
		end
	endgenerate

	// ****************************************
	// Checks
	// ****************************************
	sequence seqPushPull(int p);
		pinFunctionSelect[p] && !portOpenDrainSelect[p];
	endsequence

	// Only while the outbound pin is actually claimed; a yielded bus floats it
	sequence seqTransferThenIdle;
		(masterSpi && !coreSelectNegated) ##1
		((masterSpi && coreSelectNegated && !idleFixingEnable && driveWant[PIN_MOSI])
			and seqPushPull(PIN_MOSI));
	endsequence

	chk_single_master_drive: assert property (
		(mode == MODE_SINGLE_MASTER) && (&pinFunctionSelect) && !(|portOpenDrainSelect)
		|=> (pinOeN[PIN_MOSI:PIN_SCLK] == 6'h00) && pinOeN[PIN_MISO])
		else $error("single master pins not driven");

	chk_multi_sel_input: assert property (
		(mode == MODE_MULTI_MASTER) |=> pinOeN[PIN_SEL0])
		else $error("multi master drives select 0");

	chk_multi_float: assert property (
		(mode == MODE_MULTI_MASTER) && sel0Low
		|=> pinOeN[PIN_SCLK] && (&pinOeN[PIN_SEL3:PIN_SEL1]) && pinOeN[PIN_MOSI])
		else $error("multi master outputs not floated");

	chk_slave_float: assert property (
		(mode == MODE_SLAVE_SPI) && (!unitEnableBit || !sel0Low) |=> pinOeN[PIN_MISO])
		else $error("slave data driven while deselected");

	chk_slave_drive: assert property (
		(mode == MODE_SLAVE_SPI) && unitEnableBit && sel0Low ##0 seqPushPull(PIN_MISO)
		|=> !pinOeN[PIN_MISO] && (pinOut[PIN_MISO] == $past(coreSlaveData)))
		else $error("selected slave not driving data");

	chk_sync_master_sel: assert property (
		(mode == MODE_MASTER_SYNC) |=> (&pinOeN[PIN_SEL3:PIN_SEL0]) && pinOeN[PIN_MISO])
		else $error("sync master uses a select line");

	chk_sync_slave_drive: assert property (
		(mode == MODE_SLAVE_SYNC) ##0 seqPushPull(PIN_MISO) |=> !pinOeN[PIN_MISO])
		else $error("sync slave not driving data");

	chk_open_drain_low: assert property (
		pinFunctionSelect[PIN_SCLK] && portOpenDrainSelect[PIN_SCLK] |=> !pinOut[PIN_SCLK])
		else $error("open-drain pin driven high");

	chk_mux_release: assert property (
		!pinFunctionSelect[PIN_MOSI] |=> pinOeN[PIN_MOSI])
		else $error("unassigned pin driven");

	chk_port_free: assert property (
		(mode == MODE_SLAVE_SPI) |=> (selectPortFree[3:1] == 3'h7))
		else $error("unused select not released");

	chk_idle_hold: assert property (
		seqTransferThenIdle |=> (pinOut[PIN_MOSI] == $past(coreOutboundData, 2)))
		else $error("idle outbound data lost last bit");

	chk_idle_fixed: assert property (
		masterSpi && coreSelectNegated && idleFixingEnable && driveWant[PIN_MOSI]
		##0 seqPushPull(PIN_MOSI)
		|=> !pinOeN[PIN_MOSI] && (pinOut[PIN_MOSI] == $past(idleLevelBit)))
		else $error("idle level not applied");

	chk_fault_flag: assert property (
		(mode == MODE_MULTI_MASTER) && sel0Low |=> modeFault && !busOwned)
		else $error("mode fault not raised");

endmodule // spmc_pin_mode_control

`default_nettype wire

// *** sim/spmc_far_model.sv ***
// Far-side model: external SPI master, or a shared slave on the return line.
// Assumes the design pins use enable low while driving; every line has a pull-up.

`timescale 1ns/1ps
`default_nettype none

module spmc_far_model (
	// Design pins
	input  wire logic [spmc_pkg::SPMC_NUM_PINS-1:0] pinOut,
	input  wire logic [spmc_pkg::SPMC_NUM_PINS-1:0] pinOeN,
	// Far side controls
	input  wire logic                               farMaster,
	input  wire logic                               sel0Low,
	input  wire logic                               mosiVal,
	input  wire logic                               misoVal,
	// Resolved line levels
	output var  logic                               sclkLvl,
	output var  logic [spmc_pkg::SPMC_NUM_SEL-1:0]  selLvl,
	output var  logic                               mosiLvl,
	output var  logic                               misoLvl
);
	import spmc_pkg::*;

	logic sclkDrv = 1'h0;

	// Released line goes to its pull-up
	function automatic logic res(input logic oeN, input logic out, input logic drv,
		input logic val);
		return !oeN ? out : (drv ? val : 1'h1);
	endfunction

	// Serial clock stands still between frames
	task automatic frame(input int n);
		repeat (n) begin
			#80 sclkDrv = 1'h1;
			#80 sclkDrv = 1'h0;
		end
	endtask

	always_comb begin
		sclkLvl = res(pinOeN[PIN_SCLK], pinOut[PIN_SCLK], farMaster, sclkDrv);
		// The other master may pull select 0 low while this side is master
		selLvl[0] = res(pinOeN[PIN_SEL0], pinOut[PIN_SEL0], farMaster || sel0Low,
			!sel0Low);
		for (int i = 1; i < SPMC_NUM_SEL; i++)
			selLvl[i] = res(pinOeN[PIN_SEL0+i], pinOut[PIN_SEL0+i], 1'h0, 1'h0);
		mosiLvl = res(pinOeN[PIN_MOSI], pinOut[PIN_MOSI], farMaster, mosiVal);
		misoLvl = res(pinOeN[PIN_MISO], pinOut[PIN_MISO],
			!farMaster && !selLvl[1], misoVal);
	end

endmodule // spmc_far_model

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the serial pin mode control.
// Assumes spmc_far_model resolves every pin with pull-ups.

`timescale 1ns/1ps
`default_nettype none

module tb;
	import spmc_pkg::*;

	logic       clk, reset, masterSelectBit, faultDetectEnable, clockSyncFormSelect;
	logic       unitEnableBit, idleFixingEnable, idleLevelBit, coreSerialClock;
	logic       coreOutboundData, coreSlaveData, coreSelectNegated, modeFaultClear;
	logic       sclkLvl, mosiLvl, misoLvl, serialClockRise, serialClockFall, slaveSelected;
	logic       sampledInboundData, sampledOutboundData, modeFault, busOwned;
	logic       farMaster, sel0Low, mosiVal, misoVal;
	logic [6:0] portOpenDrainSelect, pinFunctionSelect, pinOut, pinOeN;
	logic [3:0] coreSelectOut, selLvl, selectPortFree;
	int         errCount = 0, nTests = 0, riseCount = 0, fallCount = 0;

	spmc_pin_mode_control u_spmc_pin_mode_control (.clk(clk), .reset(reset),
		.masterSelectBit(masterSelectBit), .faultDetectEnable(faultDetectEnable),
		.clockSyncFormSelect(clockSyncFormSelect), .unitEnableBit(unitEnableBit),
		.idleFixingEnable(idleFixingEnable), .idleLevelBit(idleLevelBit),
		.portOpenDrainSelect(portOpenDrainSelect), .pinFunctionSelect(pinFunctionSelect),
		.coreSerialClock(coreSerialClock), .coreSelectOut(coreSelectOut),
		.coreOutboundData(coreOutboundData), .coreSlaveData(coreSlaveData),
		.coreSelectNegated(coreSelectNegated), .modeFaultClear(modeFaultClear),
		.serialClockPinIn(sclkLvl), .selectLinePinIn(selLvl), .outboundDataPinIn(mosiLvl),
		.inboundDataPinIn(misoLvl), .pinOut(pinOut), .pinOeN(pinOeN),
		.serialClockRise(serialClockRise), .serialClockFall(serialClockFall),
		.slaveSelected(slaveSelected), .sampledInboundData(sampledInboundData),
		.sampledOutboundData(sampledOutboundData), .modeFault(modeFault),
		.busOwned(busOwned), .selectPortFree(selectPortFree));

	spmc_far_model u_spmc_far_model (.pinOut(pinOut), .pinOeN(pinOeN),
		.farMaster(farMaster), .sel0Low(sel0Low), .mosiVal(mosiVal), .misoVal(misoVal),
		.sclkLvl(sclkLvl), .selLvl(selLvl), .mosiLvl(mosiLvl), .misoLvl(misoLvl));

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (serialClockRise === 1'h1)
			riseCount <= riseCount + 1;
		if (serialClockFall === 1'h1)
			fallCount <= fallCount + 1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk7(input logic [6:0] got, input logic [6:0] exp, input string msg);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string msg);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR %0t: %s got %b exp %b", $time, msg, got, exp);
		end
	endtask

	task automatic set_mode(input logic m, input logic f, input logic s);
		masterSelectBit = m;
		faultDetectEnable = f;
		clockSyncFormSelect = s;
		tick(3);
	endtask

	task automatic test_done();
		if (errCount == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_single_master();
		set_mode(1'h1, 1'h0, 1'h0);
		coreSerialClock = 1'h1;
		coreSelectOut = 4'hA;
		coreOutboundData = 1'h1;
		tick(2);
		chk7(pinOeN, 7'h40, "single oe");
		chk7(pinOut & 7'h3F, 7'h35, "single out");
		chk7({3'h0, selectPortFree}, 7'h00, "single free");
		portOpenDrainSelect = 7'h7F;
		tick(2);
		chk7(pinOeN, 7'h75, "od oe");
		chk7(pinOut, 7'h00, "od out");
		portOpenDrainSelect = 7'h00;
		coreSelectOut = 4'hD;
		misoVal = 1'h0;
		tick(4);
		chk1(sampledInboundData, 1'h0, "selected slave data");
		coreSelectOut = 4'hF;
		tick(4);
		chk1(sampledInboundData, 1'h1, "released data line");
		coreSelectNegated = 1'h1;
		coreOutboundData = 1'h0;
		tick(2);
		chk1(pinOut[PIN_MOSI], 1'h1, "idle last bit");
		idleFixingEnable = 1'h1;
		for (int v = 0; v < 2; v++) begin
			idleLevelBit = v[0];
			tick(2);
			chk1(pinOut[PIN_MOSI], v[0], "idle fixed");
		end
		idleFixingEnable = 1'h0;
		coreSelectNegated = 1'h0;
	endtask

	task automatic t_multi_master();
		set_mode(1'h1, 1'h1, 1'h0);
		chk7(pinOeN, 7'h42, "multi oe");
		chk1(busOwned, 1'h1, "multi owned");
		sel0Low = 1'h1;
		tick(5);
		chk1(modeFault, 1'h1, "fault set");
		chk1(busOwned, 1'h0, "bus yielded");
		chk7(pinOeN, 7'h7F, "multi float");
		sel0Low = 1'h0;
		tick(4);
		modeFaultClear = 1'h1;
		tick(1);
		modeFaultClear = 1'h0;
		tick(3);
		chk1(modeFault, 1'h0, "fault cleared");
		chk7(pinOeN, 7'h42, "multi resume");
	endtask

	task automatic t_slave_spi();
		int base;
		int fallBase;
		set_mode(1'h0, 1'h0, 1'h0);
		farMaster = 1'h1;
		unitEnableBit = 1'h1;
		coreSlaveData = 1'h1;
		sel0Low = 1'h1;
		mosiVal = 1'h0;
		tick(4);
		chk7(pinOeN, 7'h3F, "slave oe");
		chk1(pinOut[PIN_MISO], 1'h1, "slave data");
		chk1(slaveSelected, 1'h1, "slave selected");
		chk7({3'h0, selectPortFree}, 7'h0E, "slave free");
		chk1(sampledOutboundData, 1'h0, "slave sampled in");
		base = riseCount;
		fallBase = fallCount;
		u_spmc_far_model.frame(4);
		tick(6);
		chk7(7'(riseCount - base), 7'h04, "clock rises");
		chk7(7'(fallCount - fallBase), 7'h04, "clock falls");
		unitEnableBit = 1'h0;
		tick(2);
		chk7(pinOeN, 7'h7F, "slave disabled");
		unitEnableBit = 1'h1;
		sel0Low = 1'h0;
		tick(4);
		chk7(pinOeN, 7'h7F, "slave deselected");
		chk1(slaveSelected, 1'h0, "slave released");
	endtask

	task automatic t_sync_modes();
		farMaster = 1'h0;
		set_mode(1'h1, 1'h1, 1'h1);
		chk7(pinOeN, 7'h5E, "sync master fault en oe");
		set_mode(1'h1, 1'h0, 1'h1);
		chk7(pinOeN, 7'h5E, "sync master oe");
		chk7({3'h0, selectPortFree}, 7'h0F, "sync master free");
		set_mode(1'h0, 1'h0, 1'h1);
		farMaster = 1'h1;
		unitEnableBit = 1'h0;
		tick(4);
		chk7(pinOeN, 7'h3F, "sync slave oe");
		chk1(slaveSelected, 1'h1, "sync slave on");
		chk7({3'h0, selectPortFree}, 7'h0F, "sync slave free");
		unitEnableBit = 1'h1;
	endtask

	task automatic t_func_select();
		farMaster = 1'h0;
		set_mode(1'h1, 1'h0, 1'h0);
		coreOutboundData = 1'h1;
		pinFunctionSelect = 7'h21;
		tick(2);
		chk7(pinOeN, 7'h5E, "partial oe");
		chk7(pinOut & 7'h3F, 7'h21, "partial out");
		chk7({3'h0, selectPortFree}, 7'h0F, "partial free");
		pinFunctionSelect = 7'h00;
		tick(2);
		chk7(pinOeN, 7'h7F, "unmuxed oe");
		chk7(pinOut, 7'h00, "unmuxed out");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset = 1'h1;
		{masterSelectBit, faultDetectEnable, clockSyncFormSelect, unitEnableBit} = 4'h0;
		{idleFixingEnable, idleLevelBit, coreSerialClock, coreOutboundData} = 4'h0;
		{coreSlaveData, coreSelectNegated, modeFaultClear, farMaster} = 4'h0;
		{sel0Low, mosiVal, misoVal} = 3'h1;
		portOpenDrainSelect = 7'h00;
		pinFunctionSelect = 7'h7F;
		coreSelectOut = 4'hF;
		tick(8);
		chk7(pinOeN, 7'h7F, "reset oe");
		reset = 1'h0;
		tick(2);
		t_single_master();
		t_multi_master();
		t_slave_spi();
		t_sync_modes();
		t_func_select();
		test_done();
	end

	initial begin
		#100us;
		errCount++;
		test_done();
	end

endmodule // tb

`default_nettype wire
